/* src/flash_command_object_waitstate.sv */
// command parameter array, launch handshake and read wait-state control
// assumes an AHB-Lite master on clk, an external command engine and array
// read port on the same clock; special_mode_pin comes from outside
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"

// Behaviour
// R1: six 16-bit parameter words, byte-wide reads and writes allowed.
// R2: writing 1 to the complete flag clears it and starts the command.
// R3: while the complete flag is clear, parameter words cannot be modified.
// R4: controller sets the flag on completion; results readable from then.
// R5: some commands write returned data back into the parameter words.
// R6: software sets the word index to match the words it loaded.
// R7: index 0 holds command code and address high; index 1 address low.
// R8: indices 2 to 5 hold data words 0 to 3, high then low byte.
// R9: a mode input selects normal or special behaviour of some registers.
// R10: a 16-bit version word, version number in bits 3 to 0.
// R11: version one is the first; all zeros and all ones mean none.
// R12: reads hitting an uncorrectable double-bit error are marked invalid.
// R13: forcing the double-fault flag never marks a read invalid.
// R14: reads to the array are stalled so array timing is met.
// R15: after reset, maximum read wait-states are enabled.
// R16: clearing the wait-state bit removes the stalls.
// R17: a new wait-state setting takes effect once the acknowledge reads 1.
// R18: lowering frequency: clock down, disable waits, poll ack, rewrite divider.
// R19: raising frequency: enable waits, poll ack, rewrite divider, clock up.
// R20: once the divider lock is set, the divider cannot be rewritten; special mode still rewrites it.
// R21: while the complete flag is 0, parameter writes are ignored, no new launch.
// R22: program or erase without a written divider does not run; access error set.
// R23: the word index selects which parameter word the window shows.
module flash_command_object_waitstate #(
	parameter int          WAIT_STATES = 2,
	parameter logic [3:0]  VERSION_NUM = 4'h1  // arbitrary version value
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// mode strap from a pin
	input  wire logic        special_mode_pin,
	// command engine
	output logic             cmd_start,
	output logic [7:0]       cmd_code,
	output logic [23:0]      cmd_addr,
	output logic [2:0]       cmd_word_count,
	input  wire logic        cmd_done,
	input  wire logic        cmd_result_valid,
	input  wire logic [63:0] cmd_result,
	// core read port
	input  wire logic        core_rd_req,
	output logic             core_rd_ready,
	output logic             core_rd_invalid,
	input  wire logic        array_dbl_err
);

	// storage
	logic [15:0]             param_word_reg [`WORD_COUNT];
	logic [2:0]              param_word_index_reg;
	logic [6:0]              divider_value_reg;
	logic                    divider_lock_reg;
	logic                    divider_loaded_reg;
	logic                    waitstate_ctrl_reg;
	logic                    force_double_fault_reg;
	logic                    command_complete_flag_reg;
	logic                    access_error_flag_reg;
	logic                    double_fault_flag_reg;
	logic                    waitstate_ack_reg;
	logic                    ws_active_reg;
	logic                    mode_meta_reg;
	logic                    special_mode_reg;
	flash_cmd_pkg::cmd_state_t cmd_state_reg;
	flash_cmd_pkg::rd_state_t  rd_state_reg;
	logic [7:0]              ws_count_reg;
	logic                    rd_dbl_reg;

	// ahb data-phase capture
	logic                    wr_pend_reg;
	logic [7:0]              wr_addr_reg;
	logic [2:0]              wr_size_reg;

	logic                    addr_phase;
	logic                    wr_en;
	logic [3:0]              wr_lanes;
	logic                    launch;
	logic                    is_prog_erase;
	logic                    rd_finish;

	// byte lanes of a write from its size and low address bits
	function automatic logic [3:0] lanes(input logic [2:0] sz, input logic [1:0] a);
		logic [3:0] l;
		l = 4'h0;
		if (sz == `HSIZE_BYTE) begin
			l[a] = 1'b1;
		end else if (sz == `HSIZE_WORD) begin
			l = 4'hF;
		end else begin
			l = a[1] ? 4'hC : 4'h3;
		end
		return l;
	endfunction

	// commands that need the divider before they may run
	function automatic logic needs_divider(input logic [7:0] c);
		unique case (c)
			`CMD_PROG_PF, `CMD_PROG_ONCE, `CMD_ERASE_ALL, `CMD_ERASE_BLK,
			`CMD_ERASE_SEC, `CMD_UNSECURE, `CMD_PROG_EE, `CMD_ERASE_EE:
				needs_divider = 1'b1;
			default:
				needs_divider = 1'b0;
		endcase
	endfunction

	assign addr_phase    = hsel & hready & htrans[1];
	assign wr_en         = wr_pend_reg;
	assign wr_lanes      = lanes(wr_size_reg, wr_addr_reg[1:0]);
	// launch only from an idle array with the flag set
	assign launch        = wr_en && (wr_addr_reg[7:2] == `OFS_STATUS >> 2) && wr_lanes[0]
	                       && hwdata[`ST_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag_reg; // R2 R21
	assign is_prog_erase = needs_divider(param_word_reg[`IDX_CMD_ADDR_HI][`HI_MSB:`HI_LSB]);
	assign rd_finish     = (rd_state_reg == flash_cmd_pkg::RD_DONE);

	// mode strap synchroniser
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_meta_reg    <= 1'b0;
			special_mode_reg <= 1'b0;
		end else begin
			mode_meta_reg    <= special_mode_pin;
			special_mode_reg <= mode_meta_reg;
		end
	end

	// ahb address phase: capture writes, answer reads with zero wait
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			wr_size_reg <= 3'h0;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata      <= 32'h0000_0000;
		end else begin
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			wr_pend_reg <= addr_phase & hwrite;
			if (addr_phase) begin
				wr_addr_reg <= haddr;
				wr_size_reg <= hsize;
			end
			if (addr_phase && !hwrite) begin
				hrdata <= 32'h0000_0000;
				unique case ({haddr[7:2], 2'b00})
					`OFS_CLKDIV: begin
						hrdata[`DIV_MSB:`DIV_LSB] <= divider_value_reg;
						hrdata[`DIV_LOCK_BIT]     <= divider_lock_reg;
						hrdata[`DIV_LOADED_BIT]   <= divider_loaded_reg;
					end
					`OFS_CONFIG: begin
						hrdata[`CFG_WAITSTATE_CTRL_BIT] <= waitstate_ctrl_reg;
						hrdata[`CFG_FORCE_DOUBLE_FAULT_BIT]  <= force_double_fault_reg;
					end
					`OFS_STATUS: begin
						hrdata[`ST_COMMAND_COMPLETE_FLAG_BIT]   <= command_complete_flag_reg;
						hrdata[`ST_ACCESS_ERROR_FLAG_BIT] <= access_error_flag_reg;
						hrdata[`ST_DOUBLE_FAULT_FLAG_BIT]   <= double_fault_flag_reg;
					end
					`OFS_PROTSTAT: hrdata[`PS_WSACK_BIT] <= waitstate_ack_reg;
					`OFS_INDEX:    hrdata[`IDX_MSB:0]    <= param_word_index_reg;
					// out-of-range index reads as zero
					`OFS_WINDOW: begin
						if (param_word_index_reg <= `LAST_INDEX) begin
							hrdata[`HI_MSB:0] <= param_word_reg[param_word_index_reg]; // R23 R4
						end
					end
					`OFS_VERSION:  hrdata[`VER_MSB:0] <= VERSION_NUM; // R10 R11
					default:       hrdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// parameter array: software bytes when idle, results on completion
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < `WORD_COUNT; i++) begin
				param_word_reg[i] <= 16'h0000;
			end
		end else if (cmd_state_reg == flash_cmd_pkg::CMD_RUN && cmd_done && cmd_result_valid) begin
			for (int i = 0; i < 4; i++) begin
				param_word_reg[i + 2] <= cmd_result[i*16 +: 16]; // R5
			end
		end else if (wr_en && (wr_addr_reg[7:2] == `OFS_WINDOW >> 2)
		             && command_complete_flag_reg && param_word_index_reg <= `LAST_INDEX) begin
			// R3 R21: locked while the flag is clear
			if (wr_lanes[0]) begin
				param_word_reg[param_word_index_reg][`LO_MSB:0] <= hwdata[`LO_MSB:0]; // R1 R23
			end
			if (wr_lanes[1]) begin
				param_word_reg[param_word_index_reg][`HI_MSB:`HI_LSB] <=
					hwdata[`HI_MSB:`HI_LSB]; // R1
			end
		end
	end

	// word index, writable only between commands
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			param_word_index_reg <= 3'h0;
		end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_INDEX >> 2)
		             && command_complete_flag_reg) begin
			param_word_index_reg <= hwdata[`IDX_MSB:0]; // R6
		end
	end

	// clock divider: lock holds until reset except in special mode
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			divider_value_reg  <= `DIV_RESET;
			divider_lock_reg   <= 1'b0;
			divider_loaded_reg <= 1'b0;
		end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_CLKDIV >> 2)
		             && command_complete_flag_reg
		             && (!divider_lock_reg || special_mode_reg)) begin // R20 R9
			divider_value_reg  <= hwdata[`DIV_MSB:`DIV_LSB];
			divider_lock_reg   <= hwdata[`DIV_LOCK_BIT];
			divider_loaded_reg <= 1'b1;
		end
	end

	// config: wait-states on from reset, fault injection bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			waitstate_ctrl_reg     <= 1'b1; // R15
			force_double_fault_reg <= 1'b0;
		end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_CONFIG >> 2)) begin
			waitstate_ctrl_reg     <= hwdata[`CFG_WAITSTATE_CTRL_BIT]; // R16
			force_double_fault_reg <= hwdata[`CFG_FORCE_DOUBLE_FAULT_BIT];
		end
	end

	// wait-state switch-over: applied only between reads, then acknowledged
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ws_active_reg     <= 1'b1; // R15
			waitstate_ack_reg <= 1'b1;
		end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_CONFIG >> 2)) begin
			waitstate_ack_reg <= 1'b0;
		end else if (!waitstate_ack_reg && rd_state_reg == flash_cmd_pkg::RD_IDLE && !core_rd_req) begin
			ws_active_reg     <= waitstate_ctrl_reg; // R17
			waitstate_ack_reg <= 1'b1; // R17
		end
	end

	// command sequencer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cmd_state_reg <= flash_cmd_pkg::CMD_IDLE;
			cmd_start     <= 1'b0;
		end else begin
			cmd_start <= 1'b0;
			unique case (cmd_state_reg)
				flash_cmd_pkg::CMD_IDLE: begin
					if (launch) begin
						if (is_prog_erase && !divider_loaded_reg) begin
							cmd_state_reg <= flash_cmd_pkg::CMD_FINISH; // R22
						end else begin
							cmd_state_reg <= flash_cmd_pkg::CMD_RUN;
							cmd_start     <= 1'b1; // R2
						end
					end
				end
				flash_cmd_pkg::CMD_RUN: begin
					if (cmd_done) begin
						cmd_state_reg <= flash_cmd_pkg::CMD_FINISH;
					end
				end
				flash_cmd_pkg::CMD_FINISH: cmd_state_reg <= flash_cmd_pkg::CMD_IDLE;
			endcase
		end
	end

	// complete flag clears on launch, sets when the sequencer finishes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			command_complete_flag_reg <= 1'b1;
		end else if (cmd_state_reg == flash_cmd_pkg::CMD_FINISH) begin
			command_complete_flag_reg <= 1'b1; // R4
		end else if (launch) begin
			command_complete_flag_reg <= 1'b0; // R2
		end
	end

	// error and fault flags: write one clears, a new event wins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			access_error_flag_reg <= 1'b0;
			double_fault_flag_reg <= 1'b0;
		end else begin
			if (launch && is_prog_erase && !divider_loaded_reg) begin
				access_error_flag_reg <= 1'b1; // R22
			end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_STATUS >> 2)
			             && hwdata[`ST_ACCESS_ERROR_FLAG_BIT]) begin
				access_error_flag_reg <= 1'b0;
			end
			if (rd_finish && (rd_dbl_reg || force_double_fault_reg)) begin
				double_fault_flag_reg <= 1'b1; // R13
			end else if (wr_en && wr_lanes[0] && (wr_addr_reg[7:2] == `OFS_STATUS >> 2)
			             && hwdata[`ST_DOUBLE_FAULT_FLAG_BIT]) begin
				double_fault_flag_reg <= 1'b0;
			end
		end
	end

	// read path: stall each read for the active wait-state count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rd_state_reg    <= flash_cmd_pkg::RD_IDLE;
			ws_count_reg    <= 8'h00;
			rd_dbl_reg      <= 1'b0;
			core_rd_ready   <= 1'b0;
			core_rd_invalid <= 1'b0;
		end else begin
			core_rd_ready   <= 1'b0;
			core_rd_invalid <= 1'b0;
			unique case (rd_state_reg)
				flash_cmd_pkg::RD_IDLE: begin
					if (core_rd_req) begin
						ws_count_reg <= ws_active_reg ? WAIT_STATES[7:0] : 8'h00; // R14 R16
						rd_state_reg <= flash_cmd_pkg::RD_WAIT;
					end
				end
				flash_cmd_pkg::RD_WAIT: begin
					if (ws_count_reg == 8'h00) begin
						rd_dbl_reg   <= array_dbl_err;
						rd_state_reg <= flash_cmd_pkg::RD_DONE;
					end else begin
						ws_count_reg <= ws_count_reg - 8'h01; // R14
					end
				end
				flash_cmd_pkg::RD_DONE: begin
					core_rd_ready   <= 1'b1;
					core_rd_invalid <= rd_dbl_reg; // R12 R13
					rd_state_reg    <= flash_cmd_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// command fields straight from the parameter and index flops
	assign cmd_code       = param_word_reg[`IDX_CMD_ADDR_HI][`HI_MSB:`HI_LSB]; // R7
	assign cmd_addr       = {param_word_reg[`IDX_CMD_ADDR_HI][`LO_MSB:0],
	                         param_word_reg[`IDX_ADDR_LO]}; // R7
	assign cmd_word_count = param_word_index_reg; // R8

endmodule

/* src/flash_cmd_defines.svh */
// register map, field positions and reset values of the command-object block
// assumes inclusion by bare name from the design module and the bench files
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// byte offsets, one aligned word each
`define OFS_CLKDIV     8'h00
`define OFS_CONFIG     8'h04
`define OFS_STATUS     8'h08
`define OFS_PROTSTAT   8'h0C
`define OFS_INDEX      8'h10
`define OFS_WINDOW     8'h14
`define OFS_VERSION    8'h18

// divider register fields
`define DIV_LSB        0
`define DIV_MSB        6
`define DIV_LOCK_BIT   7
`define DIV_LOADED_BIT 8
`define DIV_RESET      7'h00

// config register fields
`define CFG_WAITSTATE_CTRL_BIT  0
`define CFG_FORCE_DOUBLE_FAULT_BIT   1

// status register fields
`define ST_DOUBLE_FAULT_FLAG_BIT    0
`define ST_ACCESS_ERROR_FLAG_BIT  5
`define ST_COMMAND_COMPLETE_FLAG_BIT    7

// protection status fields
`define PS_WSACK_BIT   0

// index and window fields
`define IDX_MSB        2
`define WORD_COUNT     6
`define LAST_INDEX     3'h5
`define HI_LSB         8
`define HI_MSB         15
`define LO_MSB         7

// command word layout
`define IDX_CMD_ADDR_HI 3'h0
`define IDX_ADDR_LO     3'h1
`define IDX_DATA0       3'h2
`define VER_MSB         3

// ahb encodings
`define HTRANS_NONSEQ  2'h2
`define HTRANS_SEQ     2'h3
`define HSIZE_BYTE     3'h0
`define HSIZE_WORD     3'h2

// commands that program or erase the array, and the read-once command
`define CMD_PROG_PF    8'h06
`define CMD_PROG_ONCE  8'h07
`define CMD_ERASE_ALL  8'h08
`define CMD_ERASE_BLK  8'h09
`define CMD_ERASE_SEC  8'h0A
`define CMD_UNSECURE   8'h0B
`define CMD_PROG_EE    8'h11
`define CMD_ERASE_EE   8'h12
`define CMD_READ_ONCE  8'h04

`endif

/* src/flash_cmd_pkg.sv */
// types shared by the command-object block
// assumes the defines header is on the include path
package flash_cmd_pkg;

	// command sequencer states
	typedef enum logic [1:0] {
		CMD_IDLE,
		CMD_RUN,
		CMD_FINISH
	} cmd_state_t;

	// read path states
	typedef enum logic [1:0] {
		RD_IDLE,
		RD_WAIT,
		RD_DONE
	} rd_state_t;

endpackage

/* tb/flash_engine_model.sv */
// command engine stand-in on the far side of the command launch port
// assumes the block's clock and reset; slow stretches the busy time
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_engine_model (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        slow,
	input  wire logic        cmd_start,
	input  wire logic [7:0]  cmd_code,
	input  wire logic [23:0] cmd_addr,
	output logic             cmd_done,
	output logic             cmd_result_valid,
	output logic [63:0]      cmd_result
);
	logic [4:0] left_reg;
	logic       last;
	logic [15:0] a;

	assign last = left_reg == 5'h01;
	assign a = cmd_addr[15:0];

	// busy countdown; result bus toggles when idle so stale data never looks valid
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			left_reg <= 5'h00;
			cmd_done <= 1'b0;
			cmd_result_valid <= 1'b0;
			cmd_result <= 64'h0;
		end else begin
			cmd_done <= last;
			cmd_result_valid <= last && cmd_code == `CMD_READ_ONCE;
			cmd_result <= last ? {a + 16'h3, a + 16'h2, a + 16'h1, a} : ~cmd_result;
			if (cmd_start)
				left_reg <= slow ? 5'h14 : 5'h02;
			else if (left_reg != 5'h00)
				left_reg <= left_reg - 5'h01;
		end
	end
endmodule

/* tb/flash_command_object_waitstate_props.sv */
// port assertions for the command-object block
// assumes binding into flash_command_object_waitstate, one clock domain
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
module flash_command_object_waitstate_props #(
	parameter int WAIT_STATES = 2
) (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cmd_start,
	input wire logic        core_rd_req,
	input wire logic        core_rd_ready,
	input wire logic        core_rd_invalid,
	input wire logic        array_dbl_err
);
	logic st_wr_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// status write in its data phase, the only legal launch source
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			st_wr_reg <= 1'b0;
		else
			st_wr_reg <= hsel && hready && htrans[1] && hwrite && haddr == `OFS_STATUS;
	end

	sequence s_launch;
		st_wr_reg && hwdata[`ST_COMMAND_COMPLETE_FLAG_BIT];
	endsequence
	sequence s_rd_gap;
		!core_rd_ready [*2];
	endsequence

	chk_start_cause: assert property (cmd_start |-> $past(st_wr_reg && hwdata[7]))
		else $error("command launched without a status write");
	chk_start_gap: assert property (s_launch ##1 cmd_start |=> !cmd_start [*4])
		else $error("second launch while busy");
	chk_rd_stall: assert property (core_rd_req && !core_rd_ready |=> s_rd_gap)
		else $error("read finished too early");
	chk_rd_answer: assert property (core_rd_req && !core_rd_ready |-> ##[3:8] core_rd_ready)
		else $error("read never finished");
	chk_rd_single: assert property (core_rd_ready |=> !core_rd_ready)
		else $error("read ready longer than one cycle");
	chk_inv_ready: assert property (core_rd_invalid |-> core_rd_ready)
		else $error("invalid flag outside a read result");
	chk_inv_cause: assert property (core_rd_invalid |-> $past(array_dbl_err, 2))
		else $error("read marked invalid without array error");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("register access stalled or refused");
endmodule

bind flash_command_object_waitstate flash_command_object_waitstate_props #(
	.WAIT_STATES(WAIT_STATES)
) props_inst (
	.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .cmd_start(cmd_start), .core_rd_req(core_rd_req),
	.core_rd_ready(core_rd_ready), .core_rd_invalid(core_rd_invalid),
	.array_dbl_err(array_dbl_err)
);

/* tb/flash_command_object_waitstate_tb.sv */
// self-checking bench for the command-object block
// assumes the block, the engine stand-in and the checker compiled before it
`timescale 1ns/1ps
`include "flash_cmd_defines.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module flash_command_object_waitstate_tb;
	localparam int WS = 3;
	logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, special = 1'b0;
	logic        slow = 1'b0, rd_req = 1'b0, dbl_err = 1'b0, rd_dph = 1'b0, e_inv;
	logic [1:0]  htrans = 2'h0;
	logic [7:0]  haddr = 8'h00, code;
	logic [31:0] hwdata = 32'h0, hrdata, lfsr = 32'h43A37B82, e_rd;
	logic        hreadyout, hresp, cmd_start, cmd_done, res_v, rd_ready, rd_inv;
	logic [23:0] addr;
	logic [2:0]  wcnt;
	logic [63:0] res;
	logic [34:0] e_cmd;
	logic [15:0] words [6];
	logic [31:0] rd_q [$];
	logic        inv_q [$];
	logic [34:0] cmd_q [$];
	int          fail_count = 0, samples_checked = 0, cycles = 0, n;

	always #25 clk = ~clk;

	flash_command_object_waitstate #(.WAIT_STATES(WS)) flash_command_object_waitstate_inst (
		.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(`HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .special_mode_pin(special),
		.cmd_start(cmd_start), .cmd_code(code), .cmd_addr(addr), .cmd_word_count(wcnt),
		.cmd_done(cmd_done), .cmd_result_valid(res_v), .cmd_result(res),
		.core_rd_req(rd_req), .core_rd_ready(rd_ready), .core_rd_invalid(rd_inv),
		.array_dbl_err(dbl_err));
	flash_engine_model flash_engine_model_inst (
		.clk(clk), .nrst(nrst), .slow(slow), .cmd_start(cmd_start), .cmd_code(code),
		.cmd_addr(addr), .cmd_done(cmd_done), .cmd_result_valid(res_v), .cmd_result(res));

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// one single word transfer; request held until hready seen high
	task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= `HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : ~hwdata;
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rd_q.push_back(e);
		ahb(a, 1'b0, 32'h0);
	endtask

	task automatic put(input int i, input logic [15:0] w);
		words[i] = w;
		ahb(`OFS_INDEX, 1'b1, 32'(i));
		ahb(`OFS_WINDOW, 1'b1, {16'hFFFF, w});
	endtask

	// core read; counts edges from the taking edge to the ready pulse
	task automatic crd(input logic err, input int lat);
		inv_q.push_back(err);
		@(posedge clk);
		rd_req <= 1'b1;
		dbl_err <= err;
		@(posedge clk);
		rd_req <= 1'b0;
		n = 0;
		// ready is read at the edge that samples it, so n counts to that edge
		do begin @(posedge clk); n++; end while (rd_ready !== 1'b1 && n < 20);
		dbl_err <= 1'b0;
		`CHK(n, lat)
	endtask

	// scoreboard: oldest note against each result as it appears
	always @(posedge clk) begin
		rd_dph <= hsel && hreadyout && htrans[1] && !hwrite;
		if (rd_dph) begin e_rd = rd_q.pop_front(); `CHK(hrdata, e_rd) end
		if (rd_ready) begin e_inv = inv_q.pop_front(); `CHK(rd_inv, e_inv) end
		if (cmd_start) begin e_cmd = cmd_q.pop_front(); `CHK({code, addr, wcnt}, e_cmd) end
	end

	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		// reset values and an unmapped hole
		rd(`OFS_CONFIG, 32'h1);
		rd(`OFS_STATUS, 32'h80);
		rd(`OFS_PROTSTAT, 32'h1);
		rd(`OFS_CLKDIV, 32'h0);
		rd(`OFS_VERSION, 32'h1);
		rd(8'h40, 32'h0);
		// random parameter words, read back through the window
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			put(i, lfsr[15:0]);
		end
		for (int i = 0; i < 7; i++) begin
			ahb(`OFS_INDEX, 1'b1, 32'(i));
			rd(`OFS_WINDOW, i < 6 ? {16'h0, words[i]} : 32'h0);
		end
		// program without a divider: refused, access error raised
		put(0, {`CMD_PROG_PF, words[0][7:0]});
		ahb(`OFS_INDEX, 1'b1, 32'h5);
		ahb(`OFS_STATUS, 1'b1, 32'h80);
		repeat (4) @(posedge clk);
		rd(`OFS_STATUS, 32'hA0);
		ahb(`OFS_STATUS, 1'b1, 32'h20);
		ahb(`OFS_CLKDIV, 1'b1, 32'h5);
		rd(`OFS_CLKDIV, 32'h105);
		// prompt read-once with results, then a slow program that stays locked
		for (int k = 0; k < 2; k++) begin
			slow <= k == 1;
			put(0, {k ? `CMD_PROG_PF : `CMD_READ_ONCE, words[0][7:0]});
			cmd_q.push_back({words[0], words[1], 3'h5});
			ahb(`OFS_INDEX, 1'b1, 32'h5);
			ahb(`OFS_STATUS, 1'b1, 32'h80);
			rd(`OFS_STATUS, {24'h0, 8'h00});
			// only the slow engine is still busy when these land
			if (k == 1) begin
				ahb(`OFS_WINDOW, 1'b1, 32'h1234);
				ahb(`OFS_STATUS, 1'b1, 32'h80);
			end
			n = 0;
			do begin @(posedge clk); #1; n++; end while (cmd_done !== 1'b1 && n < 100);
			repeat (3) @(posedge clk);
			rd(`OFS_STATUS, 32'h80);
			if (k == 0)
				for (int i = 2; i < 6; i++) words[i] = words[1] + 16'(i - 2);
			for (int i = 2; i < 6; i++) begin
				ahb(`OFS_INDEX, 1'b1, 32'(i));
				rd(`OFS_WINDOW, {16'h0, words[i]});
			end
		end
		// divider lock holds in normal mode, special mode overrides it
		ahb(`OFS_CLKDIV, 1'b1, 32'h85);
		ahb(`OFS_CLKDIV, 1'b1, 32'h03);
		rd(`OFS_CLKDIV, 32'h185);
		special <= 1'b1;
		repeat (3) @(posedge clk);
		ahb(`OFS_CLKDIV, 1'b1, 32'h83);
		rd(`OFS_CLKDIV, 32'h183);
		// wait-states on from reset, off, forced fault, on again
		crd(1'b0, WS + 3);
		crd(1'b1, WS + 3);
		ahb(`OFS_CONFIG, 1'b1, 32'h0);
		repeat (2) @(posedge clk);
		rd(`OFS_PROTSTAT, 32'h1);
		crd(1'b0, 3);
		ahb(`OFS_STATUS, 1'b1, 32'h1);
		ahb(`OFS_CONFIG, 1'b1, 32'h2);
		crd(1'b0, 3);
		rd(`OFS_STATUS, 32'h81);
		ahb(`OFS_CONFIG, 1'b1, 32'h1);
		repeat (2) @(posedge clk);
		rd(`OFS_PROTSTAT, 32'h1);
		crd(1'b1, WS + 3);
		repeat (4) @(posedge clk);
		give_verdict();
	end
endmodule
